// File: shared/store_regs.svh
// register offsets, field positions, reset values and fixed codes of the store unit
`ifndef STORE_REGS_SVH
`define STORE_REGS_SVH

// ==========================================
// register map (byte addresses, one word each)
`define MODE_REG_OFFSET 32'h00000000
`define COUNT_OFFSET 32'h00000004
`define LAST_EA_OFFSET 32'h00000008

// ==========================================
// addressing mode register layout
`define MODE_REG_CIRC_LSB 0
`define MODE_REG_CIRC_W 8
`define MODE_REG_BLK_LSB 8
`define MODE_REG_BLK_W 5
`define MODE_REG_RESET 13'h0000

// ==========================================
// instruction word fields
`define CREG_LSB 29
`define ZERO_BIT 28
`define SRC_LSB 23
`define BASE_LSB 18
`define OFFS_LSB 13
`define MODE_LSB 9
`define RSVD_BIT 8
`define SIDE_BIT 7
`define KIND_LSB 2
`define SRC_SIDE_BIT 1
`define KIND_STORE_WORD 5'h15

// ==========================================
// address generation
`define OFFSET_SHIFT 2
`define CIRC_BASE_LO 5'h04
`define CIRC_BASE_HI 5'h07
`define WORD_STEP 32'h00000004

`endif

// File: shared/store_pkg.sv
// types of the store unit's state register; the address generator does not use them
package store_pkg;

  typedef enum logic {PH_IDLE, PH_SECOND} phase_type;

  typedef struct packed {
    logic [4:0] block_size;
    logic [7:0] circ_en;
  } addr_mode_type;

  typedef struct packed {
    logic [31:0][31:0] rf_a;
    logic [31:0][31:0] rf_b;
    addr_mode_type addr_mode;
    logic [31:0] store_cnt;
    logic [31:0] last_ea;
    phase_type phase;
    logic insn_ready;
    logic mem_valid;
    logic [31:0] mem_addr;
    logic [3:0] mem_be;
    logic [31:0] mem_wdata;
    logic [31:0] pend_addr;
    logic [3:0] pend_be;
    logic [31:0] pend_data;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_type;

endpackage

// File: shared/agu_if.sv
// carrier between the store unit and its address generator
`timescale 1ns/100ps
interface agu_if;
  logic [31:0] base;
  logic [31:0] offset;
  logic [3:0] mode;
  logic circ;
  logic [4:0] block_size;
  logic [31:0] ea;
  logic [31:0] new_base;

  modport user (output base, output offset, output mode, output circ, output block_size,
                input ea, input new_base);
  modport agu (input base, input offset, input mode, input circ, input block_size,
               output ea, output new_base);
endinterface

// File: rtl/addr_gen.sv
// effective address and base update for the unaligned word store
`timescale 1ns/100ps
`include "store_regs.svh"
module addr_gen (
  agu_if.agu port_a
);

  logic [31:0] scaled;
  logic [31:0] linear;
  logic [32:0] span;
  logic [31:0] wrap_mask;
  logic [31:0] result;

  always_comb begin
    // offset is a word count: scale before use
    scaled = port_a.offset << `OFFSET_SHIFT;
    if (port_a.mode[0]) begin
      linear = port_a.base + scaled;
    end else begin
      linear = port_a.base - scaled;
    end
    // circular buffer of 2^(n+1) bytes; upper bits of the base stay fixed
    span = 33'h000000002 << port_a.block_size;
    wrap_mask = span[31:0] - 32'h00000001;
    if (span[32]) begin
      wrap_mask = 32'hFFFFFFFF;
    end
    if (port_a.circ) begin
      result = (port_a.base & ~wrap_mask) | (linear & wrap_mask);
    end else begin
      result = linear;
    end
    port_a.new_base = result;
    // post forms store at the untouched base
    if (port_a.mode[3] && port_a.mode[1]) begin
      port_a.ea = port_a.base;
    end else begin
      port_a.ea = result;
    end
  end

endmodule

// File: rtl/unaligned_word_store.sv
// decode and execute of the unaligned word store, with register files and apb registers
//
// Contract
// - store one 32-bit word at any byte
// - address is base plus or minus optional offset
// - side bit picks data unit and file
// - offset scaled left by two bits
// - offset and pre forms store at result
// - post forms store at base, update base
// - linear, or circular for regs 4-7
// - source side bit picks data file
// - mode field: modify, register, post, add
// - lowest byte at lowest address
`timescale 1ns/100ps
`include "store_regs.svh"
module unaligned_word_store (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // instruction stream
  input wire logic insn_valid,
  input wire logic [31:0] insn,
  output logic insn_ready,
  // register file write port from the core
  input wire logic rf_we,
  input wire logic rf_side,
  input wire logic [4:0] rf_idx,
  input wire logic [31:0] rf_wdata,
  // data memory port
  output logic mem_valid,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata
);

  // ==========================================
  // helpers

  function automatic logic [31:0] rf_read(input logic side, input logic [4:0] idx,
                                          input logic [31:0][31:0] fa,
                                          input logic [31:0][31:0] fb);
    if (side) begin
      rf_read = fb[idx];
    end else begin
      rf_read = fa[idx];
    end
  endfunction

  function automatic logic pred_ok(input logic [2:0] creg, input logic z,
                                   input logic [31:0][31:0] fa,
                                   input logic [31:0][31:0] fb);
    logic [31:0] v;
    logic uncond;
    v = 32'h00000000;
    uncond = 1'b0;
    case (creg)
      3'h1: v = fb[0];
      3'h2: v = fb[1];
      3'h3: v = fb[2];
      3'h4: v = fa[1];
      3'h5: v = fa[2];
      3'h6: v = fa[0];
      default: uncond = 1'b1;
    endcase
    if (uncond) begin
      pred_ok = 1'b1;
    end else if (z) begin
      pred_ok = (v == 32'h00000000);
    end else begin
      pred_ok = (v != 32'h00000000);
    end
  endfunction

  // ==========================================
  // decode

  store_pkg::state_type s_r;
  store_pkg::state_type s_nxt;

  agu_if agu_bus ();

  addr_gen agu_inst (
    .port_a(agu_bus)
  );

  logic side_y;
  logic src_side;
  logic [4:0] base_idx;
  logic [4:0] offs_idx;
  logic [4:0] src_idx;
  logic [3:0] mode;
  logic [31:0] base_val;
  logic [31:0] offs_reg;
  logic [31:0] src_val;
  logic is_store;
  logic accept;
  logic pred;
  logic go;
  logic circ_sel;
  logic [63:0] lanes_data;
  logic [7:0] lanes_be;
  logic apb_access;
  logic apb_done;

  always_comb begin
    side_y = insn[`SIDE_BIT];
    src_side = insn[`SRC_SIDE_BIT];
    base_idx = insn[`BASE_LSB +: 5];
    offs_idx = insn[`OFFS_LSB +: 5];
    src_idx = insn[`SRC_LSB +: 5];
    mode = insn[`MODE_LSB +: 4];
    // base and offset come from the file of the chosen data unit
    base_val = rf_read(side_y, base_idx, s_r.rf_a, s_r.rf_b);
    offs_reg = rf_read(side_y, offs_idx, s_r.rf_a, s_r.rf_b);
    // stored data may come from either file
    src_val = rf_read(src_side, src_idx, s_r.rf_a, s_r.rf_b);
    // bit 8 is trusted to be zero and is not checked
    is_store = (insn[`KIND_LSB +: 5] == `KIND_STORE_WORD);
    accept = insn_valid && s_r.insn_ready && is_store;
    pred = pred_ok(insn[`CREG_LSB +: 3], insn[`ZERO_BIT], s_r.rf_a, s_r.rf_b);
    go = accept && pred;
    circ_sel = (base_idx >= `CIRC_BASE_LO) && (base_idx <= `CIRC_BASE_HI)
               && s_r.addr_mode.circ_en[{side_y, base_idx[1:0]}];
  end

  always_comb begin
    agu_bus.base = base_val;
    if (mode[2]) begin
      agu_bus.offset = offs_reg;
    end else begin
      agu_bus.offset = {27'h0000000, offs_idx};
    end
    agu_bus.mode = mode;
    agu_bus.circ = circ_sel;
    agu_bus.block_size = s_r.addr_mode.block_size;
  end

  // place the word in two adjacent memory words, lowest byte first
  always_comb begin
    lanes_data = {32'h00000000, src_val} << {agu_bus.ea[1:0], 3'b000};
    lanes_be = 8'h0F << agu_bus.ea[1:0];
  end

  // ==========================================
  // next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.mem_valid = 1'b0;
    apb_access = psel && penable;
    apb_done = apb_access && s_r.pready;

    // core write-back path into the register files
    if (rf_we) begin
      if (rf_side) begin
        s_nxt.rf_b[rf_idx] = rf_wdata;
      end else begin
        s_nxt.rf_a[rf_idx] = rf_wdata;
      end
    end

    case (s_r.phase)
      store_pkg::PH_IDLE: begin
        if (go) begin
          // first (or only) aligned word of the store
          s_nxt.mem_valid = 1'b1;
          s_nxt.mem_addr = {agu_bus.ea[31:2], 2'b00};
          s_nxt.mem_be = lanes_be[3:0];
          s_nxt.mem_wdata = lanes_data[31:0];
          s_nxt.last_ea = agu_bus.ea;
          s_nxt.store_cnt = s_r.store_cnt + 32'h00000001;
          if (lanes_be[7:4] != 4'h0) begin
            // word crosses a boundary: hold off the stream for the tail
            s_nxt.phase = store_pkg::PH_SECOND;
            s_nxt.insn_ready = 1'b0;
            s_nxt.pend_addr = {agu_bus.ea[31:2], 2'b00} + `WORD_STEP;
            s_nxt.pend_be = lanes_be[7:4];
            s_nxt.pend_data = lanes_data[63:32];
          end
          if (mode[3]) begin
            // base update wins over a core write to the same register
            if (side_y) begin
              s_nxt.rf_b[base_idx] = agu_bus.new_base;
            end else begin
              s_nxt.rf_a[base_idx] = agu_bus.new_base;
            end
          end
        end
      end
      store_pkg::PH_SECOND: begin
        s_nxt.mem_valid = 1'b1;
        s_nxt.mem_addr = s_r.pend_addr;
        s_nxt.mem_be = s_r.pend_be;
        s_nxt.mem_wdata = s_r.pend_data;
        s_nxt.phase = store_pkg::PH_IDLE;
        s_nxt.insn_ready = 1'b1;
      end
      default: begin
        s_nxt.phase = store_pkg::PH_IDLE;
      end
    endcase

    // apb: one wait state, answer registered with pready
    s_nxt.pready = apb_access && !s_r.pready;
    if (apb_access && !s_r.pready) begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h00000000;
      if (paddr == `MODE_REG_OFFSET) begin
        s_nxt.prdata = {19'h00000, s_r.addr_mode};
      end else if (paddr == `COUNT_OFFSET) begin
        s_nxt.prdata = s_r.store_cnt;
        s_nxt.pslverr = pwrite;
      end else if (paddr == `LAST_EA_OFFSET) begin
        s_nxt.prdata = s_r.last_ea;
        s_nxt.pslverr = pwrite;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    // writes land only at the edge that completes the transfer
    if (apb_done && pwrite && paddr == `MODE_REG_OFFSET) begin
      s_nxt.addr_mode = pwdata[`MODE_REG_BLK_LSB + `MODE_REG_BLK_W - 1:0];
    end
  end

  // ==========================================
  // state register

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.addr_mode <= `MODE_REG_RESET;
      s_r.phase <= store_pkg::PH_IDLE;
      s_r.insn_ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    insn_ready = s_r.insn_ready;
    mem_valid = s_r.mem_valid;
    mem_addr = s_r.mem_addr;
    mem_be = s_r.mem_be;
    mem_wdata = s_r.mem_wdata;
    pready = s_r.pready;
    pslverr = s_r.pslverr;
    prdata = s_r.prdata;
  end

  // ==========================================
  // checks

  logic [31:0] base_word;
  logic [31:0] src_copy;
  logic aligned_ea;
  assign base_word = {base_val[31:2], 2'b00};
  assign src_copy = src_val;
  assign aligned_ea = (agu_bus.ea[1:0] == 2'b00);

  chk_aligned_word: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.phase == store_pkg::PH_IDLE && go && aligned_ea)
    |=> (mem_valid && mem_be == 4'hF && insn_ready))
    else $error("aligned store did not write one full word");

  chk_split_tail: assert property (@(posedge ref_clk) disable iff (rst)
    (mem_valid && !insn_ready)
    |=> (mem_valid && mem_addr == $past(mem_addr) + `WORD_STEP
         && mem_be == ~$past(mem_be) && insn_ready))
    else $error("second word of split store wrong");

  chk_split_bytes: assert property (@(posedge ref_clk) disable iff (rst)
    (mem_valid && !insn_ready)
    |=> ($countones($past(mem_be)) + $countones(mem_be) == 4))
    else $error("split store does not cover four bytes");

  chk_pred_nop: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.phase == store_pkg::PH_IDLE && accept && !pred) |=> (!mem_valid && insn_ready))
    else $error("store issued with false predicate");

  chk_post_addr: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.phase == store_pkg::PH_IDLE && go && mode[3] && mode[1])
    |=> (mem_addr == $past(base_word)))
    else $error("post form did not store at base");

  chk_low_byte: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.phase == store_pkg::PH_IDLE && go && aligned_ea)
    |=> (mem_wdata == $past(src_copy)))
    else $error("byte order of stored word wrong");

  chk_store_count: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.phase == store_pkg::PH_IDLE && go)
    |=> (s_r.store_cnt == $past(s_r.store_cnt) + 32'h00000001))
    else $error("store count did not advance");

  chk_apb_wait: assert property (@(posedge ref_clk) disable iff (rst)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");

  // scaling mirrored here so a broken generator cannot hide behind itself
  logic [31:0] scaled_off;
  assign scaled_off = agu_bus.offset << `OFFSET_SHIFT;

  chk_addr_aligned: assert property (@(posedge ref_clk) disable iff (rst)
    mem_valid |-> (mem_addr[1:0] == 2'b00))
    else $error("memory word address not aligned");

  chk_ready_gap: assert property (@(posedge ref_clk) disable iff (rst)
    !insn_ready |=> insn_ready)
    else $error("instruction port held off too long");

  chk_linear_sum: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && !circ_sel && mode[0]) |-> (agu_bus.new_base == base_val + scaled_off))
    else $error("linear add of scaled offset wrong");

  chk_linear_diff: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && !circ_sel && !mode[0]) |-> (agu_bus.new_base == base_val - scaled_off))
    else $error("linear subtract of scaled offset wrong");

  chk_offset_addr: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.phase == store_pkg::PH_IDLE && go && !mode[1])
    |=> (mem_addr == {$past(agu_bus.new_base[31:2]), 2'b00}))
    else $error("offset or pre form did not store at result");

  chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.phase == store_pkg::PH_IDLE && !go) |=> !mem_valid)
    else $error("memory strobe without an accepted store");

endmodule

// File: verification/mem_model.sv
// byte-wide data memory that sits on the store unit's memory port
`timescale 1ns/100ps
module mem_model (
  // clock
  input wire logic ref_clk,
  // memory write port
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata
);
  // ==========================================
  // storage
  // sparse, so random addresses anywhere in the space cost nothing
  logic [7:0] bytes [logic [31:0]];

  always @(posedge ref_clk) begin
    if (mem_valid === 1'b1) begin
      for (int k = 0; k < 4; k++) begin
        if (mem_be[k]) begin
          bytes[mem_addr + 32'(k)] = mem_wdata[8*k +: 8];
        end
      end
    end
  end

  // never-written bytes read as zero, as from a memory cleared before the run
  function automatic logic [31:0] rd(input logic [31:0] a);
    return bytes.exists(a) ? {24'h0, bytes[a]} : 32'h0;
  endfunction
endmodule

// File: verification/tb.sv
// self-checking testbench of the unaligned word store
`timescale 1ns/100ps
module tb;
  // ==========================================
  // signals and bench state
  logic ref_clk = 0;
  logic rst = 1;
  logic insn_valid = 0, rf_we = 0, rf_side = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] insn = 0, rf_wdata = 0, paddr = 0, pwdata = 0;
  logic [4:0] rf_idx = 0;
  logic insn_ready, mem_valid, pready, pslverr;
  logic [31:0] mem_addr, mem_wdata, prdata;
  logic [3:0] mem_be;
  logic [31:0] ra [32], rb [32], cnt = 0, last = 0, rd;
  logic [7:0] emem [logic [31:0]];
  logic [12:0] mode_reg = 0;
  logic err;
  int mismatches = 0, n_checks = 0;
  localparam logic [3:0] modes [12] = '{4'h5, 4'h4, 4'hD, 4'hC, 4'hF, 4'hE, 4'h1, 4'h0, 4'h9, 4'h8, 4'hB, 4'hA};

  always #2.5 ref_clk = ~ref_clk;

  unaligned_word_store dut (.ref_clk(ref_clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
    .insn_ready(insn_ready), .rf_we(rf_we), .rf_side(rf_side), .rf_idx(rf_idx), .rf_wdata(rf_wdata),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata));

  mem_model mdl (.ref_clk(ref_clk), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_be(mem_be),
    .mem_wdata(mem_wdata));

  // ==========================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================
  // bus and port drivers
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rf_set(input logic side, input logic [4:0] idx, input logic [31:0] v);
    @(posedge ref_clk);
    rf_we <= 1;
    rf_side <= side;
    rf_idx <= idx;
    rf_wdata <= v;
    @(posedge ref_clk);
    rf_we <= 0;
    if (side) rb[idx] = v;
    else ra[idx] = v;
  endtask

  // predicate as the issuer means it: creg 0 and 7 always execute
  function automatic logic exp_pred(input logic [2:0] creg, input logic z);
    logic [31:0] pv;
    case (creg)
      3'h1: pv = rb[0];
      3'h2: pv = rb[1];
      3'h3: pv = rb[2];
      3'h4: pv = ra[1];
      3'h5: pv = ra[2];
      3'h6: pv = ra[0];
      default: pv = 32'h0;
    endcase
    return creg == 3'h0 || creg == 3'h7 || (z ? pv == 32'h0 : pv != 32'h0);
  endfunction

  // issues one store, updates the expected memory and registers, compares six bytes around it
  task automatic store(input logic [2:0] creg, input logic z, input logic [4:0] src, input logic [4:0] breg,
                       input logic [4:0] off, input logic [3:0] mode, input logic y, input logic s);
    logic [31:0] b, o, sum, ea, mask, v;
    logic circ, pred;
    b = y ? rb[breg] : ra[breg];
    o = mode[2] ? (y ? rb[off] : ra[off]) : {27'h0, off};
    sum = mode[0] ? b + (o << 2) : b - (o << 2);
    mask = (32'h2 << mode_reg[12:8]) - 32'h1;
    circ = breg[4:2] == 3'b001 && mode_reg[{y, breg[1:0]}];
    if (circ) sum = (b & ~mask) | (sum & mask);
    ea = mode[1] ? b : sum;
    v = s ? rb[src] : ra[src];
    pred = exp_pred(creg, z);
    @(posedge ref_clk);
    insn_valid <= 1;
    insn <= {creg, z, src, breg, off, mode, 1'b0, y, 5'h15, s, 1'b0};
    @(posedge ref_clk);
    insn_valid <= 0;
    // one store in flight at a time, split word included
    repeat (3) @(posedge ref_clk);
    if (pred) begin
      for (int k = 0; k < 4; k++) emem[ea + 32'(k)] = v[8*k +: 8];
      if (mode[3] && y) rb[breg] = sum;
      if (mode[3] && !y) ra[breg] = sum;
      cnt++;
      last = ea;
    end
    for (int k = -1; k < 5; k++) begin
      chk(mdl.rd(ea + 32'(k)), emem.exists(ea + 32'(k)) ? {24'h0, emem[ea + 32'(k)]} : 0);
    end
  endtask

  // ==========================================
  // watchdog: the tests take under two thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h9381C04A));
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    chk({31'h0, insn_ready}, 32'h1);
    chk({31'h0, mem_valid}, 32'h0);
    apb(0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    // split post-increment store, then a store through the updated base
    rf_set(0, 5'h00, 32'h00001001);
    rf_set(0, 5'h03, 32'hA1763B28);
    store(3'h0, 0, 5'h03, 5'h00, 5'h01, 4'hB, 0, 0);
    store(3'h0, 0, 5'h03, 5'h00, 5'h00, 4'h1, 0, 0);
    // read-only and unmapped places refuse and leave the count alone
    apb(1, 32'h4, 32'h5);
    chk({31'h0, err}, 32'h1);
    apb(1, 32'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(0, 32'h44, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(0, 32'h4, 32'h0);
    chk(rd, cnt);
    // zeros among the values make both senses of the predicate come up
    for (int i = 0; i < 64; i++) begin
      rf_set(i[5], i[4:0], ($urandom % 4 == 0) ? 32'h0 : ($urandom & 32'h3FFF));
    end
    mode_reg = 13'($urandom);
    apb(1, 32'h0, {19'h0, mode_reg});
    apb(0, 32'h0, 32'h0);
    chk(rd, {19'h0, mode_reg});
    repeat (300) begin
      store(3'($urandom), 1'($urandom), 5'($urandom), 5'($urandom), 5'($urandom), modes[$urandom % 12],
            1'($urandom), 1'($urandom));
    end
    store(3'h0, 0, 5'h07, 5'h05, 5'h1F, 4'hE, 1, 0);
    apb(0, 32'h8, 32'h0);
    chk(rd, last);
    apb(0, 32'h4, 32'h0);
    chk(rd, cnt);
    test_done();
  end
endmodule
